// >>> fic_pkg.sv
/*
  Constants, types and register map of the flash in-application programming controller.
  Assumes an APB slave with 32-bit data and the flash array, data registers and
  write buffer all living outside, on the same pclk domain.
*/
//
// Summary of operation
// R1 - Mode field: write, erase, read, unlock codes
// R2 - Erase/write enabled set only by hardware
// R3 - Unlock trigger starts timer, cleared at expiry
// R4 - Software writes unlock pattern before timeout
// R5 - Write launch bit cleared when write completes
// R6 - Reads only allowed while read enable set
// R7 - Read launch bit cleared when read completes
// R8 - Launch and read-enable bits set separately
// R9 - CPU stalled while flash operation runs
// R10 - Software waits for completion before next operation
// R11 - Key 55h written resets whole chip
// R12 - Buffer clear bit returns low when done
// R13 - Buffer control bits seven to two read zero
// R14 - Software keeps buffer control bit one zero
// R15 - Other key values stored, no reset
// R16 - Unlock timer length parameter, sub clock counted
package fic_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int          FIC_AW           = 12;
  localparam logic [11:0] FIC_OFF_CTRL     = 12'h000;
  localparam logic [11:0] FIC_OFF_KEY      = 12'h004;
  localparam logic [11:0] FIC_OFF_WBUF     = 12'h008;

  localparam int          FIC_BIT_EW       = 7;
  localparam int          FIC_MODE_LSB     = 4;
  localparam int          FIC_MODE_MSB     = 6;
  localparam int          FIC_BIT_TRIG     = 3;
  localparam int          FIC_BIT_WL       = 2;
  localparam int          FIC_BIT_RE       = 1;
  localparam int          FIC_BIT_RL       = 0;
  localparam int          FIC_BIT_WBC      = 0;
  localparam int          FIC_BIT_WBR      = 1;

  localparam logic [7:0]  FIC_CTRL_RST     = 8'h00;
  localparam logic [7:0]  FIC_KEY_RST      = 8'h00;
  localparam logic [7:0]  FIC_RESET_KEY    = 8'h55;

  // ----------------------------------------
  // Operation modes
  // ----------------------------------------
  localparam logic [2:0]  FIC_MODE_WRITE   = 3'h0;
  localparam logic [2:0]  FIC_MODE_ERASE   = 3'h1;
  localparam logic [2:0]  FIC_MODE_READ    = 3'h3;
  localparam logic [2:0]  FIC_MODE_UNLOCK  = 3'h6;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int          FIC_SYS_HZ       = 100_000_000;
  localparam int          FIC_SUB_HZ       = 32_768;
  localparam int          FIC_SUB_DIV      = FIC_SYS_HZ / FIC_SUB_HZ;
  localparam int          FIC_UNLOCK_TICKS = 64;

  typedef enum logic [1:0] {
    FIC_OP_NONE  = 2'h0,
    FIC_OP_WRITE = 2'h1,
    FIC_OP_ERASE = 2'h2,
    FIC_OP_READ  = 2'h3
  } fic_op_t;

  typedef struct packed {
    logic    start;
    fic_op_t op;
  } fic_flash_req_t;

endpackage : fic_pkg

// >>> fic_sub_tick.sv
/*
  Divider that turns pclk into a one-cycle sub clock enable pulse.
  Assumes pclk is the only clock; the sub clock exists only as this enable.
*/
`timescale 1ns/1ps
`default_nettype none
module fic_sub_tick
  import fic_pkg::*;
#(
  parameter int DIV = FIC_SUB_DIV
) (
  input  wire logic pclk,     // System clock
  input  wire logic presetn,  // Asynchronous reset, active low
  output logic      tick      // One-cycle sub clock enable
);

  initial begin
    if (DIV < 2) $error("fic_sub_tick: DIV must be at least 2");
  end

  localparam int CW = $clog2(DIV);

  logic [CW-1:0] cnt_r;
  wire           wrap = (cnt_r == CW'(DIV - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_r <= wrap ? '0 : cnt_r + 1'b1;
      tick  <= wrap;
    end
  end

endmodule : fic_sub_tick
`default_nettype wire

// >>> fic_top.sv
/*
  Flash in-application programming controller: control, reset key and write
  buffer control registers behind APB, unlock timer, launch and stall logic.
  Assumes the flash array answers each request with flash_done, the data
  register logic reports a correct unlock pattern on unlock_ok, and the write
  buffer answers wbuf_clear with wbuf_clear_done, all on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module fic_top
  import fic_pkg::*;
#(
  parameter int UNLOCK_TICKS = FIC_UNLOCK_TICKS,
  parameter int SUB_DIV      = FIC_SUB_DIV
) (
  input  wire logic              pclk,            // System clock
  input  wire logic              presetn,         // Asynchronous reset, active low
  input  wire logic              psel,            // APB select
  input  wire logic              penable,         // APB enable
  input  wire logic              pwrite,          // APB direction
  input  wire logic [FIC_AW-1:0] paddr,           // APB byte address
  input  wire logic [31:0]       pwdata,          // APB write data
  output logic      [31:0]       prdata,          // APB read data
  output logic                   pready,          // APB ready
  output logic                   pslverr,         // APB error on unmapped address
  output fic_flash_req_t         flash_req,       // Operation start pulse and kind
  input  wire logic              flash_done,      // Flash operation finished pulse
  input  wire logic              unlock_ok,       // Correct unlock pattern seen
  output logic                   wbuf_clear,      // Write buffer clear start pulse
  input  wire logic              wbuf_clear_done, // Write buffer clear finished
  output logic                   cpu_stall,       // Halt instruction execution
  output logic                   chip_reset_req   // Whole-chip reset pulse
);

  initial begin
    if (UNLOCK_TICKS < 1) $error("fic_top: UNLOCK_TICKS must be at least 1");
  end

  localparam int TW = $clog2(UNLOCK_TICKS + 1);

  typedef enum logic [1:0] {FIC_ST_IDLE, FIC_ST_OP, FIC_ST_CLR} fic_st_t;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire       acc     = psel & penable;
  wire       hit_c   = (paddr == FIC_OFF_CTRL);
  wire       hit_k   = (paddr == FIC_OFF_KEY);
  wire       hit_w   = (paddr == FIC_OFF_WBUF);
  wire       wr_c    = acc & pwrite & hit_c;
  wire       wr_k    = acc & pwrite & hit_k;
  wire       wr_w    = acc & pwrite & hit_w;
  wire [7:0] wd      = pwdata[7:0];

  logic          ew_r, trig_r, wl_r, re_r, rl_r, wbc_r, wbr_r;
  logic [2:0]    mode_r;
  logic [7:0]    key_r;
  logic [TW-1:0] tmr_r;
  fic_st_t       st_r;
  logic          sub_tick;

  fic_sub_tick #(.DIV(SUB_DIV)) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (sub_tick)
  );

  wire [7:0] ctrl_rd = {ew_r, mode_r, trig_r, wl_r, re_r, rl_r};
  wire [7:0] wbuf_rd = {6'h00, wbr_r, wbc_r}; // R13

  assign pready  = 1'b1;
  assign pslverr = acc & ~(hit_c | hit_k | hit_w);
  assign prdata  = hit_c ? {24'h000000, ctrl_rd} :
                   hit_k ? {24'h000000, key_r}   :
                   hit_w ? {24'h000000, wbuf_rd} : 32'h00000000;

  // ----------------------------------------
  // Control decisions
  // ----------------------------------------
  // A write that newly raises two of the three launch/enable bits is not honoured for them;
  // a bit that already reads one may be written back as one, so a read can follow its enable
  wire       up_wl   = wd[FIC_BIT_WL] & ~wl_r;
  wire       up_re   = wd[FIC_BIT_RE] & ~re_r;
  wire       up_rl   = wd[FIC_BIT_RL] & ~rl_r;
  wire       multi   = (up_wl & up_re) | (up_wl & up_rl) | (up_re & up_rl);                // R8
  wire       wr_ok   = wr_c & ~multi;
  wire [2:0] mode_nx = wr_c ? wd[FIC_MODE_MSB:FIC_MODE_LSB] : mode_r;
  wire       idle    = (st_r == FIC_ST_IDLE);
  wire       is_wr   = (mode_nx == FIC_MODE_WRITE);                                     // R1
  wire       is_er   = (mode_nx == FIC_MODE_ERASE);                                     // R1
  wire       is_rd   = (mode_nx == FIC_MODE_READ);                                      // R1
  wire       go_w    = wr_ok & wd[FIC_BIT_WL] & idle & ew_r & (is_wr | is_er);          // R5
  wire       go_r    = wr_ok & wd[FIC_BIT_RL] & idle & re_r & is_rd;                    // R6
  wire       go_c    = wr_w & wd[FIC_BIT_WBC] & idle;                                   // R12
  wire       done    = (st_r == FIC_ST_OP) & flash_done;
  wire       expire  = trig_r & sub_tick & (tmr_r == TW'(UNLOCK_TICKS - 1));            // R16
  wire       set_ew  = trig_r & unlock_ok & (mode_r == FIC_MODE_UNLOCK);
  wire       clr_ew  = wr_c & ~wd[FIC_BIT_EW];
  wire       key_hit = wr_k & (wd == FIC_RESET_KEY);                                    // R11

  // Hardware set wins over a software clear in the same cycle
  wire ew_nxt   = set_ew | (ew_r & ~clr_ew);                                            // R2
  wire trig_nxt = (wr_c & wd[FIC_BIT_TRIG]) | (trig_r & ~expire);                       // R3
  // Launch bits only stick when the operation really starts
  wire wl_nxt   = go_w | (wl_r & ~done);                                                // R5
  wire rl_nxt   = go_r | (rl_r & ~done);                                                // R7
  wire re_nxt   = wr_ok ? wd[FIC_BIT_RE] : re_r;                                        // R6
  wire wbc_nxt  = go_c | (wbc_r & ~wbuf_clear_done);                                    // R12

  fic_st_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      FIC_ST_IDLE: begin
        if (go_w | go_r) st_nxt = FIC_ST_OP;
        else if (go_c)   st_nxt = FIC_ST_CLR;
      end
      FIC_ST_OP: begin
        if (flash_done) st_nxt = FIC_ST_IDLE;
      end
      FIC_ST_CLR: begin
        if (wbuf_clear_done) st_nxt = FIC_ST_IDLE;
      end
    endcase
  end

  assign cpu_stall = (st_r == FIC_ST_OP);                                               // R9

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r   <= FIC_ST_IDLE;
      mode_r <= FIC_CTRL_RST[FIC_MODE_MSB:FIC_MODE_LSB];
      ew_r   <= 1'b0;
      trig_r <= 1'b0;
      wl_r   <= 1'b0;
      re_r   <= 1'b0;
      rl_r   <= 1'b0;
      wbc_r  <= 1'b0;
      wbr_r  <= 1'b0;
      key_r  <= FIC_KEY_RST;
    end else begin
      st_r   <= st_nxt;
      mode_r <= mode_nx;
      ew_r   <= ew_nxt;
      trig_r <= trig_nxt;
      wl_r   <= wl_nxt;
      re_r   <= re_nxt;
      rl_r   <= rl_nxt;
      wbc_r  <= wbc_nxt;
      if (wr_w) wbr_r <= wd[FIC_BIT_WBR];
      if (wr_k) key_r <= wd;                                                            // R15
    end
  end

  // Timer runs in sub clock ticks only while the trigger stands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)                 tmr_r <= '0;
    else if (!trig_r || expire)   tmr_r <= '0;                                          // R3
    else if (sub_tick)            tmr_r <= tmr_r + 1'b1;                                // R16
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_req      <= '{start: 1'b0, op: FIC_OP_NONE};
      wbuf_clear     <= 1'b0;
      chip_reset_req <= 1'b0;
    end else begin
      flash_req.start <= go_w | go_r;
      flash_req.op    <= go_r ? FIC_OP_READ : (go_w ? (is_er ? FIC_OP_ERASE : FIC_OP_WRITE)
                                                    : flash_req.op);
      wbuf_clear      <= go_c;
      chip_reset_req  <= key_hit;                                                       // R11
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_read_mode;
    @(posedge pclk) disable iff (!presetn)
      go_r |-> is_rd && re_r ##1 flash_req.start && flash_req.op == FIC_OP_READ;
  endproperty
  a_read_mode: assert property (p_read_mode) else $error("read started outside read mode"); // R1

  property p_ew_hw_set;
    @(posedge pclk) disable iff (!presetn)
      $rose(ew_r) |-> $past(trig_r) && $past(unlock_ok);
  endproperty
  a_ew_hw_set: assert property (p_ew_hw_set) else $error("enable status set without unlock"); // R2

  property p_trig_expire;
    @(posedge pclk) disable iff (!presetn)
      expire |=> !trig_r || $past(wr_c);
  endproperty
  a_trig_expire: assert property (p_trig_expire) else $error("trigger not cleared at timeout"); // R3

  property p_write_done;
    @(posedge pclk) disable iff (!presetn)
      wl_r && done |=> !wl_r && !cpu_stall;
  endproperty
  a_write_done: assert property (p_write_done) else $error("write launch not cleared"); // R5

  property p_read_gate;
    @(posedge pclk) disable iff (!presetn)
      !re_r && wr_c |=> !$rose(rl_r);
  endproperty
  a_read_gate: assert property (p_read_gate) else $error("read started while disabled"); // R6

  property p_read_fall;
    @(posedge pclk) disable iff (!presetn)
      $fell(rl_r) |-> $past(flash_done) && $past(cpu_stall);
  endproperty
  a_read_fall: assert property (p_read_fall) else $error("read launch cleared early"); // R7

  property p_stall;
    @(posedge pclk) disable iff (!presetn)
      (go_w || go_r) |=> cpu_stall && flash_req.start ##1 (cpu_stall || $past(flash_done));
  endproperty
  a_stall: assert property (p_stall) else $error("cpu not stalled during operation"); // R9

  property p_key;
    @(posedge pclk) disable iff (!presetn)
      wr_k |=> chip_reset_req == (key_r == FIC_RESET_KEY) ##1 !chip_reset_req || $past(wr_k);
  endproperty
  a_key: assert property (p_key) else $error("reset key pulse wrong"); // R11

  property p_key_store;
    @(posedge pclk) disable iff (!presetn)
      wr_k && wd != FIC_RESET_KEY |=> !chip_reset_req && key_r == $past(wd);
  endproperty
  a_key_store: assert property (p_key_store) else $error("key value not stored"); // R15

  property p_wbc_done;
    @(posedge pclk) disable iff (!presetn)
      go_c |=> wbc_r && wbuf_clear ##1 !wbuf_clear;
  endproperty
  a_wbc_done: assert property (p_wbc_done) else $error("buffer clear not started"); // R12

  property p_wbuf_zero;
    @(posedge pclk) disable iff (!presetn)
      acc && hit_w |-> prdata[31:2] == 30'h0;
  endproperty
  a_wbuf_zero: assert property (p_wbuf_zero) else $error("unused buffer bits nonzero"); // R13

endmodule : fic_top
`default_nettype wire

// >>> flash_iap_control_tb_top.sv
/*
  Self-checking testbench for the flash in-application programming controller.
  Assumes the design is built with SUB_DIV=4 and UNLOCK_TICKS=3, and that the bench
  plays the APB master, the flash array, the pattern checker and the write buffer.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_iap_control_tb_top
  import fic_pkg::*;
;
  localparam int SD = 4;
  localparam int UT = 3;
  logic              pclk, presetn, psel, penable, pwrite;
  logic [FIC_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, rdat;
  logic              pready, pslverr, err;
  fic_flash_req_t    flash_req;
  logic              flash_done, unlock_ok, wbuf_clear, wbuf_clear_done, cpu_stall, chip_reset_req;
  int                n_errors, check_count, t0;
  int                cyc = 0;

  fic_top #(.UNLOCK_TICKS(UT), .SUB_DIV(SD)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_req(flash_req), .flash_done(flash_done), .unlock_ok(unlock_ok),
    .wbuf_clear(wbuf_clear), .wbuf_clear_done(wbuf_clear_done), .cpu_stall(cpu_stall),
    .chip_reset_req(chip_reset_req));

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  // ----------------------------------------
  // Compare and bus tasks
  // ----------------------------------------
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  // Request held until pready is sampled high; data taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees ready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk_val(rdat, {24'h0, exp});
  endtask : rd

  // Called right after a control write lands
  task automatic op(input logic go, input fic_op_t k);
    #1;
    chk_bit(flash_req.start, go);
    chk_bit(cpu_stall, go);
    if (go) begin
      chk_val({30'h0, flash_req.op}, {30'h0, k});
      // Flash stays busy long enough for a register read to see the launch bit
      repeat (4) @(posedge pclk);
      chk_bit(cpu_stall, 1'b1);
      flash_done <= 1'b1;
      @(posedge pclk);
      flash_done <= 1'b0;
      #1;
      chk_bit(cpu_stall, 1'b0);
    end
  endtask : op

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(FIC_OFF_CTRL, FIC_CTRL_RST);
    rd(FIC_OFF_KEY, FIC_KEY_RST);
    rd(FIC_OFF_WBUF, 8'h00);
    apb(1'b1, FIC_OFF_CTRL, 8'h80);
    rd(FIC_OFF_CTRL, 8'h00);
    @(posedge pclk);
    unlock_ok <= 1'b1;
    @(posedge pclk);
    unlock_ok <= 1'b0;
    rd(FIC_OFF_CTRL, 8'h00);
    apb(1'b0, 12'h00c, 8'h00);
    chk_bit(err, 1'b1);
    chk_val(rdat, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_unlock;
    apb(1'b1, FIC_OFF_CTRL, 8'h68);
    t0 = cyc;
    unlock_ok <= 1'b1;
    @(posedge pclk);
    unlock_ok <= 1'b0;
    rd(FIC_OFF_CTRL, 8'he8);
    for (int i = 0; i < 20 && rdat[FIC_BIT_TRIG] === 1'b1; i++) apb(1'b0, FIC_OFF_CTRL, 8'h00);
    chk_val(rdat, 32'he0);
    chk_bit((cyc - t0) >= (UT - 1) * SD && (cyc - t0) <= UT * SD + 4, 1'b1);
    $display("test unlock done");
  endtask : t_unlock

  task automatic t_write_erase;
    apb(1'b1, FIC_OFF_CTRL, 8'h84);
    fork
      op(1'b1, FIC_OP_WRITE);
      rd(FIC_OFF_CTRL, 8'h84);
    join
    rd(FIC_OFF_CTRL, 8'h80);
    apb(1'b1, FIC_OFF_CTRL, 8'h94);
    op(1'b1, FIC_OP_ERASE);
    rd(FIC_OFF_CTRL, 8'h90);
    apb(1'b1, FIC_OFF_CTRL, 8'h10);
    rd(FIC_OFF_CTRL, 8'h10);
    apb(1'b1, FIC_OFF_CTRL, 8'h84);
    op(1'b0, FIC_OP_NONE);
    rd(FIC_OFF_CTRL, 8'h00);
    $display("test write and erase done");
  endtask : t_write_erase

  task automatic t_read;
    apb(1'b1, FIC_OFF_CTRL, 8'h31);
    op(1'b0, FIC_OP_NONE);
    rd(FIC_OFF_CTRL, 8'h30);
    apb(1'b1, FIC_OFF_CTRL, 8'h37);
    op(1'b0, FIC_OP_NONE);
    rd(FIC_OFF_CTRL, 8'h30);
    apb(1'b1, FIC_OFF_CTRL, 8'h32);
    apb(1'b1, FIC_OFF_CTRL, 8'h33);
    fork
      op(1'b1, FIC_OP_READ);
      rd(FIC_OFF_CTRL, 8'h33);
    join
    rd(FIC_OFF_CTRL, 8'h32);
    apb(1'b1, FIC_OFF_CTRL, 8'h30);
    apb(1'b1, FIC_OFF_CTRL, 8'h31);
    op(1'b0, FIC_OP_NONE);
    $display("test read done");
  endtask : t_read

  task automatic t_buf_key;
    apb(1'b1, FIC_OFF_WBUF, 8'hfd);
    #1;
    chk_bit(wbuf_clear, 1'b1);
    chk_bit(cpu_stall, 1'b0);
    rd(FIC_OFF_WBUF, 8'h01);
    @(posedge pclk);
    wbuf_clear_done <= 1'b1;
    @(posedge pclk);
    wbuf_clear_done <= 1'b0;
    rd(FIC_OFF_WBUF, 8'h00);
    apb(1'b1, FIC_OFF_KEY, 8'h12);
    #1;
    chk_bit(chip_reset_req, 1'b0);
    rd(FIC_OFF_KEY, 8'h12);
    apb(1'b1, FIC_OFF_KEY, FIC_RESET_KEY);
    #1;
    chk_bit(chip_reset_req, 1'b1);
    @(posedge pclk);
    #1;
    chk_bit(chip_reset_req, 1'b0);
    $display("test buffer and key done");
  endtask : t_buf_key

  // ----------------------------------------
  // Main sequence and verdict
  // ----------------------------------------
  task automatic results;
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  initial begin
    {presetn, psel, penable, pwrite, flash_done, unlock_ok, wbuf_clear_done} = '0;
    paddr = '0;
    pwdata = '0;
    n_errors = 0;
    check_count = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_unlock();
    t_write_erase();
    t_read();
    t_buf_key();
    results();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    results();
  end
endmodule : flash_iap_control_tb_top
`default_nettype wire
